// file: spc_pkg.sv
// Shared constants for the self-programming flash controller and its CPU-side driver.
// Assumes a single 40 MHz clock shared by both ends.
package spc_pkg;
    // Control register bit positions.
    localparam int BIT_ENABLE = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE = 2;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_SIG_READ = 5;
    localparam int BIT_RWW_BUSY = 6;
    localparam int BIT_IRQ_EN = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Command patterns in bits 5..0 of the control register.
    localparam logic [5:0] CMD_LOAD = 6'h01;
    localparam logic [5:0] CMD_ERASE = 6'h03;
    localparam logic [5:0] CMD_WRITE = 6'h05;
    localparam logic [5:0] CMD_LOCK = 6'h09;
    localparam logic [5:0] CMD_REENABLE = 6'h11;
    localparam logic [5:0] CMD_SIG = 6'h21;
    // Timed-sequence windows in cycles after the control write.
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [2:0] LOAD_WIN = 3'h3;
    localparam logic [2:0] WIN_START = 3'h1;
    // Programming time, least value, and its cycle count.
    localparam int CLK_PERIOD_PS = 25000;
    localparam longint PROG_MIN_PS = 64'd3700000000;
    localparam int PROG_CYCLES = int'((PROG_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Read-back pointer values.
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] PTR_SIG_0 = 16'h0000;
    localparam logic [15:0] PTR_CAL = 16'h0001;
    localparam logic [15:0] PTR_SIG_1 = 16'h0002;
    localparam logic [15:0] PTR_SIG_2 = 16'h0004;
    localparam logic [7:0] READ_RESERVED = 8'hFF;
    localparam logic [5:0] LOCK_UNPROGRAMMED = 6'h3F;
    // Register offsets of the CPU-side driver.
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_POINTER = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_EEPROM = 8'h10;
    localparam int CMD_ISSUE_STORE = 8;
    localparam int CMD_ISSUE_LOAD = 9;

    typedef enum logic [1:0]
    {
        SPC_OP_IDLE = 2'b00,
        SPC_OP_BUSY = 2'b01
    } spc_op_type;

    typedef enum logic [1:0]
    {
        SPC_HOST_IDLE = 2'b00,
        SPC_HOST_CTRL = 2'b01,
        SPC_HOST_INSTR = 2'b10
    } spc_host_type;
endpackage : spc_pkg

// file: spc_if.sv
// Connection between the CPU core end and the flash controller end.
// Assumes both ends run on the same clock; all strobes are one-cycle pulses.
`timescale 1ns/100ps
interface spc_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_rdata;
    logic store_req;
    logic load_req;
    logic [15:0] pointer;
    logic [15:0] data_word;
    logic load_valid;
    logic [7:0] load_result;
    logic cpu_stall;
    logic rww_blocked;
    logic irq;
    logic eeprom_write_busy;

    modport device
    (
        input ctrl_wr, ctrl_wdata, store_req, load_req, pointer, data_word, eeprom_write_busy,
        output ctrl_rdata, load_valid, load_result, cpu_stall, rww_blocked, irq
    );
    modport host
    (
        output ctrl_wr, ctrl_wdata, store_req, load_req, pointer, data_word, eeprom_write_busy,
        input ctrl_rdata, load_valid, load_result, cpu_stall, rww_blocked, irq
    );
endinterface : spc_if

// file: spc_flash_ctrl.sv
// Self-programming flash controller: control register, timed sequences, page buffer,
// lock/fuse/signature read-back and programming timer.
// Assumes the flash array sits outside and reads the page buffer through buf_index.
`timescale 1ns/100ps
module spc_flash_ctrl
    import spc_pkg::*;
#(
    parameter int PROG_TIME = PROG_CYCLES,
    parameter int WORD_BITS = 5,
    parameter int PAGE_BITS = 7,
    parameter int NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 96,
    parameter logic [7:0] FUSE_LOW = 8'hFF,
    parameter logic [7:0] FUSE_HIGH = 8'hFF,
    parameter logic [3:0] FUSE_EXT = 4'hF,
    parameter logic [7:0] SIG_BYTE_0 = 8'h5A, // Arbitrary identity value.
    parameter logic [7:0] SIG_BYTE_1 = 8'h3C, // Arbitrary identity value.
    parameter logic [7:0] SIG_BYTE_2 = 8'h01, // Arbitrary identity value.
    parameter logic [7:0] CAL_BYTE = 8'h80
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    spc_if.device bus,
    output logic flash_start,
    output logic flash_erase,
    output logic flash_write,
    output logic [PAGE_BITS-1:0] flash_page,
    input wire logic [WORD_BITS-1:0] buf_index,
    output logic [15:0] buf_word,
    output logic [5:0] lock_state
);
    localparam int PAGE_WORDS = 1 << WORD_BITS;
    localparam int PAGE_LSB = WORD_BITS + 1;

    logic [15:0] page_buf [PAGE_WORDS];
    logic buf_loaded;
    logic armed;
    logic [5:0] armed_cmd;
    logic [2:0] win_count;
    logic irq_en;
    logic rww_busy;
    logic target_rww;
    logic [31:0] op_count;
    spc_op_type op_state;
    logic ctrl_take;
    logic store_take;
    logic load_take;
    logic start_op;
    logic reenable_now;
    logic [PAGE_BITS-1:0] page_sel;
    logic self_prog_enable_bit;

    function automatic logic [7:0] fuse_lock_read(input logic [15:0] ptr, input logic [5:0] locks);
        case (ptr)
            PTR_FUSE_LOW: fuse_lock_read = FUSE_LOW;
            PTR_LOCK: fuse_lock_read = {2'b11, locks};
            PTR_FUSE_EXT: fuse_lock_read = {4'hF, FUSE_EXT};
            PTR_FUSE_HIGH: fuse_lock_read = FUSE_HIGH;
            default: fuse_lock_read = READ_RESERVED;
        endcase
    endfunction : fuse_lock_read

    function automatic logic [7:0] sig_read(input logic [15:0] ptr);
        case (ptr)
            PTR_SIG_0: sig_read = SIG_BYTE_0;
            PTR_CAL: sig_read = CAL_BYTE;
            PTR_SIG_1: sig_read = SIG_BYTE_1;
            PTR_SIG_2: sig_read = SIG_BYTE_2;
            default: sig_read = READ_RESERVED;
        endcase
    endfunction : sig_read

    assign page_sel = bus.pointer[PAGE_LSB +: PAGE_BITS];
    // Control writes are refused while an EEPROM write or a programming run is under way.
    assign ctrl_take = bus.ctrl_wr && !bus.eeprom_write_busy && op_state == SPC_OP_IDLE;
    assign reenable_now = ctrl_take && bus.ctrl_wdata[5:0] == CMD_REENABLE;
    assign store_take = bus.store_req && armed && win_count <= STORE_WIN
        && !bus.eeprom_write_busy;
    assign load_take = bus.load_req && armed && win_count <= LOAD_WIN
        && (armed_cmd == CMD_LOCK || armed_cmd == CMD_SIG) && !bus.eeprom_write_busy;
    assign start_op = store_take
        && (armed_cmd == CMD_ERASE || armed_cmd == CMD_WRITE || armed_cmd == CMD_LOCK);

    // Arming and window counting of the timed sequence.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            armed <= 1'b0;
            armed_cmd <= CTRL_RESET[5:0];
            win_count <= 3'h0;
            irq_en <= 1'b0;
        end
        else if (ctrl_take)
        begin
            armed <= bus.ctrl_wdata[BIT_ENABLE] && !reenable_now;
            armed_cmd <= bus.ctrl_wdata[5:0];
            win_count <= WIN_START;
            irq_en <= bus.ctrl_wdata[BIT_IRQ_EN];
        end
        else if (armed)
        begin
            if (store_take || load_take)
            begin
                armed <= 1'b0;
            end
            else if (armed_cmd == CMD_SIG && win_count >= LOAD_WIN)
            begin
                armed <= 1'b0;
            end
            else if (win_count >= STORE_WIN)
            begin
                armed <= 1'b0;
            end
            win_count <= win_count + WIN_START;
        end
    end

    // Programming timer and section bookkeeping.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_state <= SPC_OP_IDLE;
            op_count <= 32'h0000_0000;
            target_rww <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_page <= '0;
            flash_start <= 1'b0;
        end
        else
        begin
            flash_start <= start_op && armed_cmd != CMD_LOCK;
            case (op_state)
                SPC_OP_IDLE:
                begin
                    if (start_op)
                    begin
                        op_state <= SPC_OP_BUSY;
                        op_count <= 32'(PROG_TIME - 1);
                        flash_erase <= armed_cmd == CMD_ERASE;
                        flash_write <= armed_cmd == CMD_WRITE;
                        flash_page <= page_sel;
                        target_rww <= armed_cmd != CMD_LOCK
                            && 32'(page_sel) < 32'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
                    end
                end
                SPC_OP_BUSY:
                begin
                    if (op_count == 32'h0000_0000)
                    begin
                        op_state <= SPC_OP_IDLE;
                        flash_erase <= 1'b0;
                        flash_write <= 1'b0;
                    end
                    else
                    begin
                        op_count <= op_count - 32'h0000_0001;
                    end
                end
                default:
                begin
                    op_state <= SPC_OP_IDLE;
                end
            endcase
        end
    end

    // The busy flag stays set until software writes the reenable pattern.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rww_busy <= 1'b0;
        end
        else if (start_op && (armed_cmd == CMD_ERASE || armed_cmd == CMD_WRITE)
            && 32'(page_sel) < 32'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE))
        begin
            rww_busy <= 1'b1;
        end
        else if (reenable_now)
        begin
            rww_busy <= 1'b0;
        end
    end

    // Temporary page buffer.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < PAGE_WORDS; i++)
            begin
                page_buf[i] <= 16'h0000;
            end
            buf_loaded <= 1'b0;
        end
        else if ((op_state == SPC_OP_BUSY && flash_write && op_count == 32'h0000_0000)
            || reenable_now || (buf_loaded && bus.eeprom_write_busy))
        begin
            for (int i = 0; i < PAGE_WORDS; i++)
            begin
                page_buf[i] <= 16'h0000;
            end
            buf_loaded <= 1'b0;
        end
        else if (store_take && armed_cmd == CMD_LOAD)
        begin
            page_buf[bus.pointer[1 +: WORD_BITS]] <= bus.data_word;
            buf_loaded <= 1'b1;
        end
    end

    // Buffer word for the array, lock bits (a zero programs, reads zero) and load answers.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buf_word <= 16'h0000;
            lock_state <= LOCK_UNPROGRAMMED;
            bus.load_valid <= 1'b0;
            bus.load_result <= 8'h00;
        end
        else
        begin
            buf_word <= page_buf[buf_index];
            if (start_op && armed_cmd == CMD_LOCK)
            begin
                lock_state <= lock_state & bus.data_word[5:0];
            end
            bus.load_valid <= load_take;
            if (load_take)
            begin
                bus.load_result <= armed_cmd == CMD_LOCK
                    ? fuse_lock_read(bus.pointer, lock_state)
                    : sig_read(bus.pointer);
            end
        end
    end

    assign self_prog_enable_bit = armed || op_state == SPC_OP_BUSY;
    assign bus.ctrl_rdata = {irq_en, rww_busy, armed_cmd[5:1] & {5{self_prog_enable_bit}},
        self_prog_enable_bit};
    assign bus.irq = irq_en && !self_prog_enable_bit;
    assign bus.cpu_stall = op_state == SPC_OP_BUSY && (flash_erase || flash_write)
        && !target_rww;
    assign bus.rww_blocked = rww_busy || (op_state == SPC_OP_BUSY && target_rww);
endmodule : spc_flash_ctrl

// file: spc_cpu_host.sv
// CPU-side end: takes orders from software over APB and replays them as control
// writes, store and load instructions towards the flash controller.
// Assumes the APB master follows the standard two-phase protocol on ref_clk.
`timescale 1ns/100ps
module spc_cpu_host
    import spc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    spc_if.host bus
);
    spc_host_type state;
    logic [7:0] ctrl_value;
    logic want_store;
    logic want_load;
    logic [15:0] pointer;
    logic [15:0] data_word;
    logic eeprom_busy;
    logic refused;
    logic [7:0] last_result;
    logic result_valid;
    logic access;
    logic cmd_write;

    assign access = psel && penable;
    // A command write waits while the core is stalled or a sequence is still going out.
    assign pready = !(psel && pwrite && paddr == OFF_CMD
        && (bus.cpu_stall || state != SPC_HOST_IDLE));
    assign pslverr = 1'b0;
    assign cmd_write = access && pready && pwrite && paddr == OFF_CMD;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pointer <= 16'h0000;
            data_word <= 16'h0000;
            eeprom_busy <= 1'b0;
        end
        else if (access && pwrite)
        begin
            case (paddr)
                OFF_POINTER: pointer <= pwdata[15:0];
                OFF_DATA: data_word <= pwdata[15:0];
                OFF_EEPROM: eeprom_busy <= pwdata[0];
                default: pointer <= pointer;
            endcase
        end
    end

    // Control write, then the instruction in the next cycle, well inside both windows.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SPC_HOST_IDLE;
            ctrl_value <= CTRL_RESET;
            want_store <= 1'b0;
            want_load <= 1'b0;
            refused <= 1'b0;
        end
        else
        begin
            case (state)
                SPC_HOST_IDLE:
                begin
                    if (cmd_write)
                    begin
                        refused <= eeprom_busy;
                        ctrl_value <= pwdata[7:0];
                        want_store <= pwdata[CMD_ISSUE_STORE];
                        want_load <= pwdata[CMD_ISSUE_LOAD];
                        if (!eeprom_busy)
                        begin
                            state <= SPC_HOST_CTRL;
                        end
                    end
                end
                SPC_HOST_CTRL: state <= SPC_HOST_INSTR;
                SPC_HOST_INSTR: state <= SPC_HOST_IDLE;
                default: state <= SPC_HOST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            last_result <= 8'h00;
            result_valid <= 1'b0;
        end
        else if (bus.load_valid)
        begin
            last_result <= bus.load_result;
            result_valid <= 1'b1;
        end
        else if (cmd_write)
        begin
            result_valid <= 1'b0;
        end
    end

    always_comb
    begin
        case (paddr)
            OFF_CMD: prdata = {24'h00_0000, ctrl_value};
            OFF_POINTER: prdata = {16'h0000, pointer};
            OFF_DATA: prdata = {16'h0000, data_word};
            OFF_STATUS: prdata = {11'h000, refused, bus.irq, bus.rww_blocked, bus.cpu_stall,
                result_valid, last_result, bus.ctrl_rdata};
            OFF_EEPROM: prdata = {31'h0000_0000, eeprom_busy};
            default: prdata = 32'h0000_0000;
        endcase
    end

    assign bus.ctrl_wr = state == SPC_HOST_CTRL;
    assign bus.ctrl_wdata = ctrl_value;
    assign bus.store_req = state == SPC_HOST_INSTR && want_store;
    assign bus.load_req = state == SPC_HOST_INSTR && want_load;
    assign bus.pointer = pointer;
    assign bus.data_word = data_word;
    assign bus.eeprom_write_busy = eeprom_busy;
endmodule : spc_cpu_host

// file: spc_chk.sv
// Checker on the link between the CPU end and the flash controller end.
// Assumes one clock domain and is instantiated beside the interface.
`timescale 1ns/100ps
module spc_chk
    import spc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic store_req,
    input wire logic load_req,
    input wire logic load_valid,
    input wire logic [7:0] load_result,
    input wire logic cpu_stall,
    input wire logic rww_blocked,
    input wire logic irq,
    input wire logic eeprom_write_busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    irq_level_a: assert property (irq == (ctrl_rdata[BIT_IRQ_EN] && !ctrl_rdata[BIT_ENABLE]))
        else $error("irq level differs from enable state");
    load_answer_a: assert property ($rose(load_valid) |-> $past(load_req))
        else $error("load answer without load request");
    result_hold_a: assert property ($changed(load_result) |-> load_valid)
        else $error("load result changed without an answer");
    busy_flag_a: assert property (rww_blocked |-> ctrl_rdata[BIT_RWW_BUSY])
        else $error("section blocked while busy flag clear");
    reenable_clear_a: assert property (ctrl_wr && ctrl_wdata[5:0] == CMD_REENABLE
        && !eeprom_write_busy && !ctrl_rdata[BIT_ENABLE] |=> !ctrl_rdata[BIT_RWW_BUSY])
        else $error("busy flag kept after re-enable");
    eeprom_block_a: assert property (eeprom_write_busy && !ctrl_rdata[BIT_ENABLE]
        |=> !ctrl_rdata[BIT_ENABLE])
        else $error("command taken during eeprom write");
    sig_expire_a: assert property ($rose(ctrl_rdata[BIT_SIG_READ])
        |-> ##[1:4] !ctrl_rdata[BIT_SIG_READ])
        else $error("signature mode outlived its window");
    lock_expire_a: assert property ($rose(ctrl_rdata[BIT_LOCK_SET]) && !store_req
        ##1 !store_req [*5] |-> !ctrl_rdata[BIT_LOCK_SET])
        else $error("lock-set mode outlived its window");
    run_enable_a: assert property ($rose(cpu_stall || rww_blocked)
        |-> ctrl_rdata[BIT_ENABLE] [*8])
        else $error("enable bit dropped during a run");
endmodule : spc_chk

// file: self_program_flash_control_test.sv
// Testbench joining the CPU end and the flash controller end, driven over APB.
// Assumes a 40 MHz clock and a shortened programming time of 20 cycles.
`timescale 1ns/100ps
module self_program_flash_control_test
    import spc_pkg::*;
;
    logic ref_clk = 0;
    logic rstn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic pready;
    logic flash_start;
    logic flash_erase;
    logic flash_write;
    logic [6:0] flash_page;
    logic [4:0] buf_index = 0;
    logic [15:0] buf_word;
    logic [5:0] lock_state;
    logic [31:0] rd;
    int errors = 0;
    int num_checks = 0;
    int starts = 0;

    spc_if link ();
    spc_flash_ctrl #(.PROG_TIME(20), .FUSE_LOW(8'hA5), .FUSE_HIGH(8'h5A), .FUSE_EXT(4'h6))
        u_spc_flash_ctrl (.ref_clk(ref_clk), .rstn(rstn), .bus(link.device),
        .flash_start(flash_start), .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_page(flash_page), .buf_index(buf_index), .buf_word(buf_word),
        .lock_state(lock_state));
    spc_cpu_host u_spc_cpu_host (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .bus(link.host));
    spc_chk u_spc_chk (.ref_clk(ref_clk), .rstn(rstn), .ctrl_wr(link.ctrl_wr),
        .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata), .store_req(link.store_req),
        .load_req(link.load_req), .load_valid(link.load_valid), .load_result(link.load_result),
        .cpu_stall(link.cpu_stall), .rww_blocked(link.rww_blocked), .irq(link.irq),
        .eeprom_write_busy(link.eeprom_write_busy));

    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Counts run-start pulses, so that each started erase or write run is seen exactly once; lock runs give no pulse.
    always @(posedge ref_clk)
    begin
        if (flash_start === 1'b1)
            starts <= starts + 1;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task complete_run;
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // One APB transfer; entered just after a rising edge, leaves one idle cycle.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 2000)
            begin
                errors++;
                complete_run;
            end
            @(posedge ref_clk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task settle;
        repeat (3) @(negedge ref_clk);
    endtask : settle

    task wait_done;
        int n;
        for (n = 0; n < 200 && link.ctrl_rdata[BIT_ENABLE] !== 1'b0; n++)
            @(negedge ref_clk);
        if (n == 200)
        begin
            errors++;
            complete_run;
        end
        @(posedge ref_clk);
    endtask : wait_done

    task see_buf(input logic [4:0] i, input logic [15:0] exp);
        buf_index <= i;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("buffer word", buf_word, exp);
        @(posedge ref_clk);
    endtask : see_buf

    task load_word(input logic [4:0] i, input logic [15:0] d);
        apb(1, OFF_POINTER, {26'h0, i, 1'b0});
        apb(1, OFF_DATA, {16'h0, d});
        apb(1, OFF_CMD, 32'h0000_0101);
        repeat (2) @(posedge ref_clk);
    endtask : load_word

    task read_mode(input logic [31:0] cmd, input logic [15:0] ptr, input logic [7:0] exp);
        apb(1, OFF_POINTER, {16'h0, ptr});
        apb(1, OFF_CMD, cmd);
        repeat (2) @(posedge ref_clk);
        apb(0, OFF_STATUS, 0);
        check("read back", rd[15:8], exp);
        check("mode cleared", rd[0], 1'b0);
    endtask : read_mode

    task s_reset;
        apb(0, OFF_STATUS, 0);
        check("status", rd, 32'h0000_0000);
        check("locks", lock_state, 6'h3F);
        see_buf(0, 16'h0000);
    endtask : s_reset

    task s_load_write;
        load_word(0, 16'hC0DE);
        load_word(31, 16'h1234);
        see_buf(0, 16'hC0DE);
        see_buf(31, 16'h1234);
        apb(1, OFF_POINTER, 32'h0000_00C0);
        apb(1, OFF_CMD, 32'h0000_0185);
        settle;
        check("write run", flash_write, 1'b1);
        check("page", flash_page, 7'd3);
        check("blocked", link.rww_blocked, 1'b1);
        check("no stall", link.cpu_stall, 1'b0);
        check("run starts", starts, 1);
        wait_done;
        check("irq", link.irq, 1'b1);
        apb(0, OFF_STATUS, 0);
        check("busy kept", rd[BIT_RWW_BUSY], 1'b1);
        see_buf(0, 16'h0000);
        apb(1, OFF_CMD, 32'h0000_0011);
        apb(0, OFF_STATUS, 0);
        check("busy cleared", rd[BIT_RWW_BUSY], 1'b0);
    endtask : s_load_write

    task s_erase;
        load_word(5, 16'hBEEF);
        apb(1, OFF_POINTER, 32'h0000_193E);
        apb(1, OFF_CMD, 32'h0000_0103);
        settle;
        check("erase run", flash_erase, 1'b1);
        check("page", flash_page, 7'd100);
        check("stall", link.cpu_stall, 1'b1);
        check("run starts", starts, 2);
        apb(1, OFF_CMD, 32'h0000_0011);
        check("stall over", link.cpu_stall, 1'b0);
        see_buf(5, 16'h0000);
    endtask : s_erase

    task s_lock;
        apb(1, OFF_DATA, 32'h0000_00FE);
        apb(1, OFF_CMD, 32'h0000_0109);
        settle;
        check("lock readable", {link.cpu_stall, link.rww_blocked}, 2'b00);
        wait_done;
        check("locks", lock_state, 6'h3E);
        read_mode(32'h0000_0209, PTR_LOCK, 8'hFE);
        read_mode(32'h0000_0209, PTR_FUSE_LOW, 8'hA5);
        read_mode(32'h0000_0209, PTR_FUSE_HIGH, 8'h5A);
        read_mode(32'h0000_0209, PTR_FUSE_EXT, 8'hF6);
        read_mode(32'h0000_0221, PTR_SIG_0, 8'h5A);
        read_mode(32'h0000_0221, PTR_SIG_1, 8'h3C);
        read_mode(32'h0000_0221, PTR_SIG_2, 8'h01);
        read_mode(32'h0000_0221, PTR_CAL, 8'h80);
        read_mode(32'h0000_0221, 16'h0006, READ_RESERVED);
    endtask : s_lock

    task s_expire;
        logic [7:0] cmds [3];
        cmds = '{8'h09, 8'h03, 8'h21};
        foreach (cmds[i])
        begin
            apb(1, OFF_CMD, {24'h0, cmds[i]});
            repeat (8) @(posedge ref_clk);
            apb(0, OFF_STATUS, 0);
            check("window over", rd[5:0], 6'h00);
            check("no erase", flash_erase, 1'b0);
        end
    endtask : s_expire

    task s_eeprom;
        load_word(2, 16'hA55A);
        apb(1, OFF_EEPROM, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        see_buf(2, 16'h0000);
        apb(1, OFF_CMD, 32'h0000_0105);
        settle;
        check("no write", flash_write, 1'b0);
        check("run starts", starts, 2);
        apb(0, OFF_STATUS, 0);
        check("refused", rd[20], 1'b1);
        apb(1, OFF_EEPROM, 32'h0000_0000);
    endtask : s_eeprom

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        s_reset;
        s_load_write;
        s_erase;
        s_lock;
        s_expire;
        s_eeprom;
        complete_run;
    end
endmodule : self_program_flash_control_test
